/* File: core/hall_consts.svh */
`ifndef HALL_CONSTS_SVH
`define HALL_CONSTS_SVH

// register indices
`define REG_CMD 8'h00
`define REG_STATUS 8'h01
`define REG_SEL_STATE 8'h02
`define REG_RESULT_Z 8'h03
`define REG_RESULT_Y 8'h04
`define REG_RESULT_X 8'h05
`define REG_RESULT_T 8'h06
`define REG_REF_SELECT 8'h19
`define REG_REF_DELTA 8'h1A
`define REG_Z_THRESH 8'h1B
`define REG_Y_THRESH 8'h1C
`define REG_INTERVAL 8'h1D
`define REG_OVERSAMPLE 8'h1E
`define REG_READBACK 8'h20

// command fields
`define CMD_MODE_MSB 7
`define CMD_MODE_LSB 4
`define MODE_IDLE 4'h8
`define MODE_CONT 4'h1
`define MODE_WAKE 4'h2
`define MODE_SINGLE 4'h3

// status bits
`define ST_CONT 0
`define ST_WAKE 1
`define ST_SINGLE 2
`define ST_FAIL 3
`define ST_DRDY 4

// resets and timing
`define MID_SCALE 16'h8000
`define REF_RST 16'h8000
`define THRESH_RST 16'h0100
`define CONV_BASE_US 165
`define CLK_MHZ 25
`define CONV_BASE_CYC ((`CONV_BASE_US) * (`CLK_MHZ))
`define INTERVAL_UNIT_US 10
`define INTERVAL_UNIT_CYC ((`INTERVAL_UNIT_US) * (`CLK_MHZ))

`endif

/* File: core/hall_pkg.sv */
package hall_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_MEAS = 5'h02,
		ST_COMPARE = 5'h04,
		ST_STANDBY = 5'h08,
		ST_FINISH = 5'h10
	} seq_state_t;
	typedef logic [3:0] chan_sel_t;
endpackage : hall_pkg

/* File: core/axis_window.sv */
`timescale 1ns/1ps
// flags when reading departs from reference by more than threshold
module axis_window (
	// operands
	input wire logic [15:0] reading,
	input wire logic [15:0] reference,
	input wire logic [15:0] threshold,
	input wire logic enable,
	// result
	output logic exceeded
);
	logic [15:0] diff;
	always_comb begin
		diff = (reading >= reference) ? reading - reference :
			reference - reading;
		exceeded = enable && (diff > threshold);
	end
endmodule : axis_window

/* File: core/hall_mode_seq.sv */
`timescale 1ns/1ps
`include "hall_consts.svh"
module hall_mode_seq
	import hall_pkg::*;
#(
	parameter int FIELD_BITS = 16
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// analog front end samples
	input wire logic [FIELD_BITS-1:0] FIELD_Z,
	input wire logic [FIELD_BITS-1:0] FIELD_Y,
	input wire logic [FIELD_BITS-1:0] FIELD_X,
	input wire logic [15:0] TEMP,
	// pins
	output logic INT_PIN,
	output logic [3:0] MODE_STATE
);
	seq_state_t state_reg;
	logic [3:0] mode_reg;
	chan_sel_t sel_reg;
	logic stop_req_reg;
	logic int_reg;
	logic fail_reg;
	logic drdy_reg;
	logic [15:0] rdata_reg;
	logic [15:0] ref_sel_reg;
	logic [15:0] ref_delta_reg;
	logic [15:0] zth_reg;
	logic [15:0] yth_reg;
	logic [15:0] interval_reg;
	logic [15:0] osr_reg;
	logic [15:0] res_z_reg;
	logic [15:0] res_y_reg;
	logic [15:0] res_x_reg;
	logic [15:0] res_t_reg;
	logic [15:0] ref_z_reg;
	logic [15:0] ref_y_reg;
	logic [15:0] ref_x_reg;
	logic [23:0] timer_reg;
	logic [1:0] chan_idx_reg;
	// front end inputs cross from the analog domain
	logic [15:0] fz_s1, fz_s2, fy_s1, fy_s2, fx_s1, fx_s2, ft_s1, ft_s2;
	logic measuring;
	logic busy_mode;
	logic cmd_wr;
	logic rb_rd;
	logic [3:0] cmd_mode;
	logic exc_z, exc_y, exc_x;
	logic [23:0] conv_cyc;
	logic [23:0] pause_cyc;

	always_ff @(posedge SYS_CLK) begin
		fz_s1 <= 16'(FIELD_Z);
		fz_s2 <= fz_s1;
		fy_s1 <= 16'(FIELD_Y);
		fy_s2 <= fy_s1;
		fx_s1 <= 16'(FIELD_X);
		fx_s2 <= fx_s1;
		ft_s1 <= TEMP;
		ft_s2 <= ft_s1;
	end

	assign measuring = (state_reg == ST_MEAS) || (state_reg == ST_COMPARE);
	assign busy_mode = (mode_reg == `MODE_CONT) || (mode_reg == `MODE_WAKE);
	assign cmd_wr = WR && (ADDR == `REG_CMD);
	assign rb_rd = RD && (ADDR == `REG_READBACK);
	assign cmd_mode = WDATA[`CMD_MODE_MSB:`CMD_MODE_LSB];
	// oversample shifts the base conversion length
	assign conv_cyc = 24'(`CONV_BASE_CYC) << osr_reg[2:0];
	assign pause_cyc = 24'(interval_reg) * 24'(`INTERVAL_UNIT_CYC);

	// delta is a signed offset from the captured baseline
	axis_window win_z (.reading(res_z_reg), .reference(ref_z_reg),
		.threshold(zth_reg), .enable(sel_reg[3]), .exceeded(exc_z));
	axis_window win_y (.reading(res_y_reg), .reference(ref_y_reg),
		.threshold(yth_reg), .enable(sel_reg[2]), .exceeded(exc_y));
	axis_window win_x (.reading(res_x_reg), .reference(ref_x_reg),
		.threshold(yth_reg), .enable(sel_reg[1]), .exceeded(exc_x));

	// mode sequencer
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			mode_reg <= 4'h0;
			sel_reg <= 4'h0;
			stop_req_reg <= 1'b0;
			timer_reg <= 24'h000000;
			chan_idx_reg <= 2'h0;
		end else begin
			if (cmd_wr && cmd_mode == `MODE_IDLE && state_reg != ST_IDLE)
				stop_req_reg <= 1'b1;
			unique case (state_reg)
			ST_IDLE: begin
				stop_req_reg <= 1'b0;
				if (cmd_wr && (cmd_mode == `MODE_CONT ||
					cmd_mode == `MODE_WAKE || cmd_mode == `MODE_SINGLE)) begin
					mode_reg <= cmd_mode;
					sel_reg <= WDATA[3:0];
					state_reg <= ST_MEAS;
					timer_reg <= conv_cyc;
					chan_idx_reg <= 2'h3;
				end
			end
			ST_MEAS: begin
				if (timer_reg > 24'h000001) begin
					timer_reg <= timer_reg - 24'h000001;
				end else if (chan_idx_reg != 2'h0) begin
					chan_idx_reg <= chan_idx_reg - 2'h1;
					timer_reg <= conv_cyc;
				end else begin
					state_reg <= ST_COMPARE;
				end
			end
			ST_COMPARE: begin
				if (mode_reg == `MODE_SINGLE) begin
					state_reg <= ST_FINISH;
				end else if (stop_req_reg || (cmd_wr && cmd_mode == `MODE_IDLE))
				begin
					state_reg <= ST_FINISH;
				end else begin
					state_reg <= ST_STANDBY;
					timer_reg <= pause_cyc + 24'h000001;
				end
			end
			ST_STANDBY: begin
				if (stop_req_reg || (cmd_wr && cmd_mode == `MODE_IDLE)) begin
					state_reg <= ST_FINISH;
				end else if (timer_reg > 24'h000001) begin
					timer_reg <= timer_reg - 24'h000001;
				end else begin
					state_reg <= ST_MEAS;
					timer_reg <= conv_cyc;
					chan_idx_reg <= 2'h3;
				end
			end
			ST_FINISH: begin
				state_reg <= ST_IDLE;
				mode_reg <= 4'h0;
				sel_reg <= 4'h0;
				stop_req_reg <= 1'b0;
			end
			endcase
		end
	end

	// results latched at end of pass; deselected channels keep their last value
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			res_z_reg <= `MID_SCALE;
			res_y_reg <= `MID_SCALE;
			res_x_reg <= `MID_SCALE;
			res_t_reg <= 16'h0000;
		end else if (state_reg == ST_MEAS && timer_reg <= 24'h000001 &&
			chan_idx_reg == 2'h0) begin
			// unsigned offset binary keeps field sign about mid-scale
			if (sel_reg[3]) res_z_reg <= fz_s2;
			if (sel_reg[2]) res_y_reg <= fy_s2;
			if (sel_reg[1]) res_x_reg <= fx_s2;
			if (sel_reg[0]) res_t_reg <= ft_s2;
		end
	end

	// wake reference: captured result or midscale, plus delta
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ref_z_reg <= `REF_RST;
			ref_y_reg <= `REF_RST;
			ref_x_reg <= `REF_RST;
		end else if (cmd_wr && state_reg == ST_IDLE &&
			cmd_mode == `MODE_WAKE) begin
			ref_z_reg <= (ref_sel_reg[0] ? res_z_reg : `MID_SCALE)
				+ ref_delta_reg;
			ref_y_reg <= (ref_sel_reg[0] ? res_y_reg : `MID_SCALE)
				+ ref_delta_reg;
			ref_x_reg <= (ref_sel_reg[0] ? res_x_reg : `MID_SCALE)
				+ ref_delta_reg;
		end
	end

	// interrupt pin; readback clears it unless a pass that sets it is completing
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			int_reg <= 1'b0;
		end else if (mode_reg == `MODE_WAKE) begin
			if (state_reg == ST_COMPARE && (exc_z || exc_y || exc_x))
				int_reg <= 1'b1;
			else if (rb_rd)
				int_reg <= 1'b0;
		end else if (state_reg == ST_COMPARE) begin
			int_reg <= 1'b1;
		end else if (state_reg == ST_MEAS || rb_rd) begin
			int_reg <= 1'b0;
		end
	end

	// status flags; hardware set wins over the read clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			fail_reg <= 1'b0;
			drdy_reg <= 1'b0;
		end else begin
			if ((WR || RD) && busy_mode && !rb_rd &&
				!(RD && ADDR == `REG_STATUS) &&
				!(cmd_wr && cmd_mode == `MODE_IDLE))
				fail_reg <= 1'b1;
			else if (rb_rd && mode_reg == `MODE_CONT && measuring)
				fail_reg <= 1'b1;
			else if (RD && ADDR == `REG_STATUS)
				fail_reg <= 1'b0;
			if (state_reg == ST_COMPARE && (mode_reg != `MODE_WAKE ||
				exc_z || exc_y || exc_x))
				drdy_reg <= 1'b1;
			else if (rb_rd)
				drdy_reg <= 1'b0;
		end
	end

	// configuration registers, writable only while idle
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ref_sel_reg <= 16'h0000;
			ref_delta_reg <= 16'h0000;
			zth_reg <= `THRESH_RST;
			yth_reg <= `THRESH_RST;
			interval_reg <= 16'h0000;
			osr_reg <= 16'h0000;
		end else if (WR && state_reg == ST_IDLE && !busy_mode) begin
			unique case (ADDR)
			`REG_REF_SELECT: ref_sel_reg <= WDATA;
			`REG_REF_DELTA: ref_delta_reg <= WDATA;
			`REG_Z_THRESH: zth_reg <= WDATA;
			`REG_Y_THRESH: yth_reg <= WDATA;
			`REG_INTERVAL: interval_reg <= WDATA;
			`REG_OVERSAMPLE: osr_reg <= WDATA;
			default: ;
			endcase
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rdata_reg <= 16'h0000;
		end else if (RD) begin
			rdata_reg <= 16'h0000;
			if (rb_rd) begin
				if (!(mode_reg == `MODE_CONT && measuring))
					rdata_reg <= res_z_reg;
			end else if (ADDR == `REG_STATUS) begin
				rdata_reg <= {11'h000, drdy_reg, fail_reg,
					mode_reg == `MODE_SINGLE, mode_reg == `MODE_WAKE,
					mode_reg == `MODE_CONT};
			end else if (!busy_mode) begin
				unique case (ADDR)
				`REG_SEL_STATE: rdata_reg <= {11'h000, state_reg};
				`REG_RESULT_Z: rdata_reg <= res_z_reg;
				`REG_RESULT_Y: rdata_reg <= res_y_reg;
				`REG_RESULT_X: rdata_reg <= res_x_reg;
				`REG_RESULT_T: rdata_reg <= res_t_reg;
				`REG_REF_SELECT: rdata_reg <= ref_sel_reg;
				`REG_REF_DELTA: rdata_reg <= ref_delta_reg;
				`REG_Z_THRESH: rdata_reg <= zth_reg;
				`REG_Y_THRESH: rdata_reg <= yth_reg;
				`REG_INTERVAL: rdata_reg <= interval_reg;
				`REG_OVERSAMPLE: rdata_reg <= osr_reg;
				default: rdata_reg <= 16'h0000;
				endcase
			end
		end
	end

	logic [3:0] mode_out_reg;
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			mode_out_reg <= 4'h0;
		else
			mode_out_reg <= {stop_req_reg, state_reg == ST_STANDBY,
				measuring, state_reg == ST_IDLE};
	end

	assign RDATA = rdata_reg;
	assign INT_PIN = int_reg;
	assign MODE_STATE = mode_out_reg;

	chk_single_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_reg == ST_COMPARE && mode_reg == `MODE_SINGLE
		|=> ##1 state_reg == ST_IDLE) else $error("single no idle");
	chk_int_after_pass: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_reg == ST_COMPARE && mode_reg == `MODE_CONT
		|=> INT_PIN) else $error("int not high");
	chk_int_meas_low: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_reg == ST_MEAS && mode_reg == `MODE_CONT && !rb_rd
		|=> !INT_PIN) else $error("int high in pass");
	chk_fail_on_access: assert property (@(posedge SYS_CLK) disable iff (RST)
		WR && ADDR != `REG_CMD && mode_reg == `MODE_CONT
		|=> fail_reg) else $error("no fail flag");
	chk_cfg_locked: assert property (@(posedge SYS_CLK) disable iff (RST)
		WR && ADDR == `REG_INTERVAL && busy_mode
		|=> $stable(interval_reg)) else $error("cfg written");
	chk_idle_finish: assert property (@(posedge SYS_CLK) disable iff (RST)
		cmd_wr && cmd_mode == `MODE_IDLE && state_reg == ST_MEAS
		|=> state_reg != ST_IDLE) else $error("pass cut");
	chk_wake_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
		INT_PIN && mode_reg == `MODE_WAKE && !rb_rd
		|=> INT_PIN) else $error("wake int dropped");
	chk_mode_select: assert property (@(posedge SYS_CLK) disable iff (RST)
		cmd_wr && state_reg == ST_IDLE && cmd_mode == `MODE_CONT
		|=> mode_reg == `MODE_CONT && sel_reg == $past(WDATA[3:0]))
		else $error("bad mode latch");
	chk_reset_idle: assert property (@(posedge SYS_CLK)
		RST |=> state_reg == ST_IDLE && !INT_PIN && sel_reg == 4'h0)
		else $error("bad reset");
	cov_cont: cover property (@(posedge SYS_CLK)
		mode_reg == `MODE_CONT && state_reg == ST_STANDBY);
	cov_wake_int: cover property (@(posedge SYS_CLK)
		mode_reg == `MODE_WAKE && INT_PIN);
	cov_single: cover property (@(posedge SYS_CLK)
		mode_reg == `MODE_SINGLE && state_reg == ST_FINISH);
endmodule : hall_mode_seq

/* File: testbench/host_bus_model.sv */
`timescale 1ns/1ps
`include "hall_consts.svh"
// host side of the register port; bench scenarios call its tasks
module host_bus_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [15:0] rdata,
	// pin
	input wire logic int_pin
);
	initial begin
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// released lines invert so a stale value never passes for fresh
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		@(negedge clk);
		d = rdata;
	endtask : read_reg
	// a fetch during a continuous-mode pass would fail, so wait for the pin
	task automatic readback(output logic [15:0] d, output logic ok);
		int n;
		n = 0;
		while (int_pin !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		ok = int_pin;
		read_reg(`REG_READBACK, d);
	endtask : readback
endmodule : host_bus_model

/* File: testbench/hall_mode_seq_tb.sv */
`timescale 1ns/1ps
`include "hall_consts.svh"
module hall_mode_seq_tb;
	import hall_pkg::*;
	logic sys_clk;
	logic rst;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic [15:0] fz;
	logic [15:0] fy;
	logic [15:0] fx;
	logic [15:0] temp;
	logic int_pin;
	logic [3:0] mode_state;
	int bad_count;
	int num_checks;
	int seed;
	logic [15:0] rdv;
	logic [15:0] exp_w;
	logic ok;

	hall_mode_seq i_dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FIELD_Z(fz),
		.FIELD_Y(fy), .FIELD_X(fx), .TEMP(temp), .INT_PIN(int_pin),
		.MODE_STATE(mode_state));
	host_bus_model i_host (.clk(sys_clk), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .int_pin(int_pin));

	always #20 sys_clk = ~sys_clk;

	function automatic logic [15:0] mode_cmd(input logic [3:0] m,
		input logic [3:0] sel);
		return {8'h00, m, sel};
	endfunction : mode_cmd
	function automatic logic exceeds(input logic [15:0] v, r, t);
		return ((v > r) ? v - r : r - v) > t;
	endfunction : exceeds

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic check_word(input string what, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : check_word
	task automatic check_bit(input string what, input logic e,
		input logic g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : check_bit
	task automatic give_up(input string what);
		bad_count++;
		$display("BAD %s expected event seen timeout", what);
		complete_run();
	endtask : give_up
	task automatic wait_int(input logic lvl, input int bound);
		int n;
		n = 0;
		while (int_pin !== lvl && n < bound) begin
			@(negedge sys_clk);
			n++;
		end
		if (int_pin !== lvl) give_up("pin wait");
	endtask : wait_int
	task automatic wait_state(input int idx, input logic v, input int bound);
		int n;
		n = 0;
		while (mode_state[idx] !== v && n < bound) begin
			@(negedge sys_clk);
			n++;
		end
		if (mode_state[idx] !== v) give_up("state wait");
	endtask : wait_state
	// front end is two-flop synced, so values settle well before use
	task automatic set_fields(input logic [15:0] z);
		@(posedge sys_clk);
		fz <= z;
		fy <= 16'($random(seed));
		fx <= 16'($random(seed));
		temp <= 16'($random(seed));
	endtask : set_fields

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		seed = 23;
		bad_count = 0;
		num_checks = 0;
		fz = `MID_SCALE;
		fy = `MID_SCALE;
		fx = `MID_SCALE;
		temp = 16'h0000;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check_bit("pin after reset", 1'b0, int_pin);
		check_word("state after reset", 16'h0001, {12'h000, mode_state});
		i_host.read_reg(`REG_STATUS, rdv);
		check_word("status after reset", 16'h0000, rdv);
		i_host.read_reg(`REG_Z_THRESH, rdv);
		check_word("z threshold reset", `THRESH_RST, rdv);
		i_host.write_reg(`REG_REF_SELECT, 16'h0000);
		i_host.write_reg(`REG_REF_DELTA, 16'h0000);
		i_host.write_reg(`REG_INTERVAL, 16'h0003);
		exp_w = 16'($random(seed));
		i_host.write_reg(`REG_Y_THRESH, exp_w);
		i_host.read_reg(`REG_Y_THRESH, rdv);
		check_word("y threshold", exp_w, rdv);
		// single pass with a positive z field
		exp_w = {1'b1, 15'($random(seed))} | 16'h0001;
		set_fields(exp_w);
		repeat (4) @(posedge sys_clk);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_SINGLE, 4'b1001));
		repeat (2) @(negedge sys_clk);
		check_bit("single measuring", 1'b1, mode_state[1]);
		wait_state(0, 1'b1, 20000);
		i_host.read_reg(`REG_RESULT_Z, rdv);
		check_word("single z", exp_w, rdv);
		// continuous with zero field; refused accesses first
		set_fields(`MID_SCALE);
		repeat (4) @(posedge sys_clk);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_CONT, 4'b1001));
		i_host.read_reg(`REG_Z_THRESH, rdv);
		check_word("refused read", 16'h0000, rdv);
		i_host.read_reg(`REG_READBACK, rdv);
		check_word("early readback", 16'h0000, rdv);
		i_host.read_reg(`REG_STATUS, rdv);
		check_bit("fail flag", 1'b1, rdv[`ST_FAIL]);
		check_bit("cont flag", 1'b1, rdv[`ST_CONT]);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_SINGLE, 4'b1000));
		i_host.read_reg(`REG_STATUS, rdv);
		check_bit("fail on mode", 1'b1, rdv[`ST_FAIL]);
		check_bit("mode kept", 1'b1, rdv[`ST_CONT]);
		i_host.read_reg(`REG_STATUS, rdv);
		check_bit("fail cleared", 1'b0, rdv[`ST_FAIL]);
		i_host.write_reg(`REG_INTERVAL, 16'h0000);
		i_host.read_reg(`REG_STATUS, rdv);
		check_bit("fail on write", 1'b1, rdv[`ST_FAIL]);
		check_bit("pin low measuring", 1'b0, int_pin);
		wait_int(1'b1, 18000);
		// unread pass: pin holds over the 750-cycle pause, then drops
		repeat (700) @(negedge sys_clk);
		check_bit("pin held", 1'b1, int_pin);
		check_bit("standby", 1'b1, mode_state[2]);
		check_bit("not idle", 1'b0, mode_state[0]);
		wait_int(1'b0, 200);
		check_bit("next pass", 1'b1, mode_state[1]);
		i_host.readback(rdv, ok);
		check_bit("pin before fetch", 1'b1, ok);
		check_word("cont z", `MID_SCALE, rdv);
		wait_int(1'b0, 3);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_IDLE, 4'b0000));
		wait_state(0, 1'b1, 18000);
		i_host.read_reg(`REG_INTERVAL, rdv);
		check_word("interval kept", 16'h0003, rdv);
		i_host.write_reg(`REG_INTERVAL, 16'h0000);
		i_host.read_reg(`REG_INTERVAL, rdv);
		check_word("interval", 16'h0000, rdv);
		// wake on z only; y and x wander freely, z sits on threshold
		set_fields(16'h8100);
		repeat (4) @(posedge sys_clk);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_WAKE, 4'b1000));
		i_host.write_reg(`REG_Z_THRESH, 16'h0000);
		wait_state(2, 1'b1, 18000);
		ok = exceeds(16'h8100, `MID_SCALE, `THRESH_RST);
		check_bit("wake quiet", ok, int_pin);
		set_fields(16'h8101);
		wait_int(1'b1, 36000);
		repeat (1000) @(negedge sys_clk);
		ok = exceeds(16'h8101, `MID_SCALE, `THRESH_RST);
		check_bit("wake held", ok, int_pin);
		i_host.readback(rdv, ok);
		check_word("wake z", 16'h8101, rdv);
		wait_int(1'b0, 3);
		wait_state(1, 1'b1, 18000);
		i_host.write_reg(`REG_CMD, mode_cmd(`MODE_IDLE, 4'b0000));
		repeat (100) @(negedge sys_clk);
		check_bit("idle deferred", 1'b0, mode_state[0]);
		check_bit("stop pending", 1'b1, mode_state[3]);
		wait_state(0, 1'b1, 18000);
		i_host.read_reg(`REG_Z_THRESH, rdv);
		check_word("write refused", `THRESH_RST, rdv);
		complete_run();
	end
endmodule : hall_mode_seq_tb
